// *** design/rrs_defines.svh ***
// Purpose: constants of the radio register serial master
// Assumes: included by its bare name from the tick and serial master design files
// Notes: frame layout, pin reset levels and timing figures
// Notes on behaviour
// - frame: header, read/write, address, 16 data
// - every field travels most significant bit first
// - writes shift out on fall, sampled on rise
// - reads: radio shifts on rise, device samples fall
// - device releases data line after read address
// - capture read word at first fall, load high
// - radio releases on rise, device drives after next
// - reads always sixteen bits, upper bits undefined
// - fast write: header selects write-only register
// - short fast write: 3 address, 5 data bits
// - normal frames still accepted in fast mode
// - wide register: high word first, then low
// - at least two shift periods between halves
// - init writes 14 addresses from 17 down to 1, fixed order
// - after reset: modem line high, others released; shift clock and load enable driven low
// - chip enable high selects normal radio mode
// - normal frames always start with header 101b
// - device alone drives shift clock and load enable
`ifndef RRS_DEFINES_SVH
`define RRS_DEFINES_SVH

// ************************************************************
// frame layout
// ************************************************************
`define RRS_HDR_NORMAL 3'h5
`define RRS_LEN_NORMAL 5'h19
`define RRS_LEN_FAST16 5'h10
`define RRS_LEN_FAST8 5'h08
`define RRS_DATA_BITS 5'h10
`define RRS_READ_RELEASE 5'h11
`define RRS_LAST_BIT 5'h01
`define RRS_W32_HI 31:16
`define RRS_W32_LO 15:0

// ************************************************************
// initialisation order, first address in the top bits
// ************************************************************
`define RRS_INIT_ORDER {5'h11, 5'h0f, 5'h0e, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h02, 5'h01}
`define RRS_INIT_LAST 4'hd

// ************************************************************
// reset levels and timing
// ************************************************************
`define RRS_MODEM_RST 1'b1
`define RRS_OE_N_RST 1'b1
`define RRS_READY_RST 1'b1
`define RRS_GAP_NS 500
`define RRS_LINK_KHZ 12000
`define RRS_HALF_DEF 3
`define RRS_HALF_MIN 3

`endif

// *** design/rrs_pkg.sv ***
// Purpose: types shared by the radio register serial master
// Assumes: nothing beyond the defines header
// Notes: fsm codes are one-hot
package rrs_pkg;

    typedef enum logic [2:0] {
        KIND_WRITE = 3'h0,
        KIND_READ = 3'h1,
        KIND_WRITE32 = 3'h2,
        KIND_FAST16 = 3'h3,
        KIND_FAST8 = 3'h4
    } rrs_kind_e;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_FETCH = 4'h2,
        S_BUSY = 4'h4
    } rrs_sys_state_e;

    typedef enum logic [3:0] {
        L_IDLE = 4'h1,
        L_SHIFT = 4'h2,
        L_LOAD = 4'h4,
        L_GAP = 4'h8
    } rrs_link_state_e;

    typedef struct packed {
        rrs_kind_e kind;
        logic [2:0] hdr;
        logic [4:0] addr;
        logic [31:0] data;
    } rrs_cmd_s;

    typedef struct packed {
        logic wide;
        logic [31:0] data;
    } rrs_init_s;

    typedef struct packed {
        rrs_sys_state_e state;
        rrs_cmd_s cmd;
        logic req_tgl;
        logic ack_seen;
        logic ready;
        logic rsp_valid;
        logic [15:0] rsp_data;
        logic init_active;
        logic [3:0] idx;
        logic [4:0] init_addr;
        logic init_done;
        logic modem;
        logic ce;
        logic ce_oe_n;
        logic sync;
        logic sync_oe_n;
    } rrs_sys_s;

    typedef struct packed {
        rrs_link_state_e state;
        logic [24:0] sh;
        logic [4:0] bits;
        logic sck;
        logic serial_load_enable;
        logic sdo;
        logic oe_n;
        logic [15:0] rx;
        logic [15:0] rsp;
        logic [1:0] edges;
        logic second;
        logic [7:0] gap;
        logic ack_tgl;
        logic req_seen;
        logic rd;
        logic w32;
    } rrs_link_s;

endpackage

// *** design/rrs_sync.sv ***
// Purpose: two flip-flop synchroniser for levels
// Assumes: input is a level or a toggle, never a pulse
// Notes: the first stage feeds only the second
module rrs_sync
    import rrs_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_r <= '0;
            o_q <= '0;
        end
        else
        begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule

// *** design/rrs_tick.sv ***
// Purpose: half-period strobe for the shift clock
// Assumes: i_run held high for the whole frame
// Notes: restarting on i_run gives a full half period of setup
`include "rrs_defines.svh"
module rrs_tick
    import rrs_pkg::*;
#(
    parameter int HALF = `RRS_HALF_DEF
)
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_run,
    output logic o_tick
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic tick_nxt;

    always_comb
    begin
        cnt_nxt = 8'h0;
        tick_nxt = 1'b0;
        if (i_run)
        begin
            if (cnt_r == 8'(HALF - 1))
                tick_nxt = 1'b1;
            else
                cnt_nxt = cnt_r + 8'h1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnt_r <= 8'h0;
            o_tick <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            o_tick <= tick_nxt;
        end
    end
endmodule

// *** design/rrs_serial_master.sv ***
// Purpose: serial master for the radio register port plus power-up pins
// Assumes: i_clk_link is the radio's baseband clock; commands on i_clk_sys
// Notes: one command at a time; words cross by toggle handshake
`include "rrs_defines.svh"
module rrs_serial_master
    import rrs_pkg::*;
#(
    parameter int HALF = `RRS_HALF_DEF,
    parameter int LINK_KHZ = `RRS_LINK_KHZ
)
(
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_clk_link,
    input wire logic i_cmd_valid,
    input wire rrs_cmd_s i_cmd,
    output logic o_cmd_ready,
    output logic o_rsp_valid,
    output logic [15:0] o_rsp_data,
    input wire logic i_init_start,
    output logic [4:0] o_init_addr,
    input wire rrs_init_s i_init_entry,
    output logic o_init_done,
    input wire logic i_pins_enable,
    input wire logic i_radio_chip_enable,
    input wire logic i_radio_sync_control,
    output logic o_modem_data_line,
    output logic o_radio_chip_enable,
    output logic o_radio_chip_enable_oe_n,
    output logic o_radio_sync_control,
    output logic o_radio_sync_control_oe_n,
    output logic o_serial_shift_clock,
    output logic o_serial_load_enable,
    output logic o_serial_data_line,
    output logic o_serial_data_line_oe_n,
    input wire logic i_serial_data_line
);
    // least gap rounds up to whole link cycles; two shift periods if longer
    localparam int GAP_TIME_CYC = (`RRS_GAP_NS * LINK_KHZ + 999999) / 1000000;
    localparam int GAP_CYC = (GAP_TIME_CYC > 4 * HALF) ? GAP_TIME_CYC : 4 * HALF;

    initial
    begin
        if (HALF < `RRS_HALF_MIN || GAP_CYC > 255)
            $error("rrs_serial_master: HALF must be at least 3 and gap below 256");
    end

    localparam rrs_sys_s SYS_RST = '{state: S_IDLE, cmd: '{kind: KIND_WRITE, default: '0},
        ready: `RRS_READY_RST, modem: `RRS_MODEM_RST, ce_oe_n: `RRS_OE_N_RST,
        sync_oe_n: `RRS_OE_N_RST, default: '0};
    localparam rrs_link_s LINK_RST = '{state: L_IDLE, oe_n: `RRS_OE_N_RST, default: '0};

    // ************************************************************
    // frame helpers
    // ************************************************************
    function automatic logic [24:0] frame(input rrs_kind_e kind, input logic [2:0] hdr,
                                          input logic [4:0] addr, input logic [15:0] d);
        case (kind)
            KIND_READ: frame = {`RRS_HDR_NORMAL, 1'b1, addr, 16'h0};
            KIND_FAST16: frame = {hdr, d[12:0], 9'h0};
            KIND_FAST8: frame = {hdr, d[4:0], 17'h0};
            default: frame = {`RRS_HDR_NORMAL, 1'b0, addr, d};
        endcase
    endfunction

    function automatic logic [4:0] frame_len(input rrs_kind_e kind);
        case (kind)
            KIND_FAST16: frame_len = `RRS_LEN_FAST16;
            KIND_FAST8: frame_len = `RRS_LEN_FAST8;
            default: frame_len = `RRS_LEN_NORMAL;
        endcase
    endfunction

    function automatic logic [4:0] init_addr(input logic [3:0] idx);
        logic [69:0] order;
        order = `RRS_INIT_ORDER;
        init_addr = order[69 - 5 * idx -: 5];
    endfunction

    // ************************************************************
    // link reset and crossings
    // ************************************************************
    logic lrst_meta_r;
    logic lrst_r;

    always_ff @(posedge i_clk_link or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            lrst_meta_r <= 1'b1;
            lrst_r <= 1'b1;
        end
        else
        begin
            lrst_meta_r <= 1'b0;
            lrst_r <= lrst_meta_r;
        end
    end

    rrs_sys_s s;
    rrs_sys_s sn;
    rrs_link_s l;
    rrs_link_s ln;
    logic req_s;
    logic ack_s;
    logic sdi_s;
    logic tick;

    rrs_sync #(.W(1)) u_req_sync (.i_clk(i_clk_link), .i_rst(lrst_r), .i_d(s.req_tgl), .o_q(req_s));
    rrs_sync #(.W(1)) u_ack_sync (.i_clk(i_clk_sys), .i_rst(i_sys_rst), .i_d(l.ack_tgl), .o_q(ack_s));
    rrs_sync #(.W(1)) u_sdi_sync (.i_clk(i_clk_link), .i_rst(lrst_r), .i_d(i_serial_data_line),
        .o_q(sdi_s));

    rrs_tick #(.HALF(HALF)) u_tick (
        .i_clk(i_clk_link),
        .i_rst(lrst_r),
        .i_run(l.state == L_SHIFT || l.state == L_LOAD),
        .o_tick(tick)
    );

    // ************************************************************
    // system side: commands, init sequence, power-up pins
    // ************************************************************
    always_comb
    begin
        sn = s;
        sn.rsp_valid = 1'b0;
        sn.init_done = 1'b0;
        sn.ce = i_radio_chip_enable;
        sn.sync = i_radio_sync_control;
        sn.ce_oe_n = ~i_pins_enable;
        sn.sync_oe_n = ~i_pins_enable;
        case (s.state)
            S_IDLE:
            begin
                if (i_init_start)
                begin
                    sn.init_active = 1'b1;
                    sn.idx = 4'h0;
                    sn.init_addr = init_addr(4'h0);
                    sn.ready = 1'b0;
                    sn.state = S_FETCH;
                end
                else if (i_cmd_valid)
                begin
                    sn.cmd = i_cmd;
                    sn.req_tgl = ~s.req_tgl;
                    sn.ready = 1'b0;
                    sn.state = S_BUSY;
                end
            end
            S_FETCH:
            begin
                sn.cmd.kind = i_init_entry.wide ? KIND_WRITE32 : KIND_WRITE;
                sn.cmd.hdr = `RRS_HDR_NORMAL;
                sn.cmd.addr = s.init_addr;
                sn.cmd.data = i_init_entry.data;
                sn.req_tgl = ~s.req_tgl;
                sn.state = S_BUSY;
            end
            S_BUSY:
            begin
                if (ack_s != s.ack_seen)
                begin
                    sn.ack_seen = ack_s;
                    if (!s.init_active)
                    begin
                        sn.rsp_valid = 1'b1;
                        sn.rsp_data = l.rsp;
                        sn.ready = 1'b1;
                        sn.state = S_IDLE;
                    end
                    else if (s.idx == `RRS_INIT_LAST)
                    begin
                        sn.init_active = 1'b0;
                        sn.init_done = 1'b1;
                        sn.modem = 1'b0;
                        sn.ready = 1'b1;
                        sn.state = S_IDLE;
                    end
                    else
                    begin
                        sn.idx = s.idx + 4'h1;
                        sn.init_addr = init_addr(s.idx + 4'h1);
                        sn.state = S_FETCH;
                    end
                end
            end
            default: sn = SYS_RST;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            s <= SYS_RST;
        else
            s <= sn;
    end

    // ************************************************************
    // link side: frame shifter
    // ************************************************************
    always_comb
    begin
        ln = l;
        case (l.state)
            L_IDLE:
            begin
                if (req_s != l.req_seen)
                begin
                    // the command word has been stable since before the toggle
                    ln.req_seen = req_s;
                    ln.rd = (s.cmd.kind == KIND_READ);
                    ln.w32 = (s.cmd.kind == KIND_WRITE32);
                    ln.second = 1'b0;
                    ln.sh = frame(s.cmd.kind, s.cmd.hdr, s.cmd.addr,
                        (s.cmd.kind == KIND_WRITE32) ? s.cmd.data[`RRS_W32_HI] : s.cmd.data[`RRS_W32_LO]);
                    ln.bits = frame_len(s.cmd.kind);
                    ln.sdo = ln.sh[24];
                    ln.oe_n = 1'b0;
                    ln.state = L_SHIFT;
                end
            end
            L_SHIFT:
            begin
                if (tick && !l.sck)
                    ln.sck = 1'b1;
                else if (tick)
                begin
                    ln.sck = 1'b0;
                    ln.bits = l.bits - 5'h01;
                    ln.sh = {l.sh[23:0], 1'b0};
                    ln.sdo = l.sh[23];
                    if (l.rd && l.bits <= `RRS_DATA_BITS)
                        ln.rx = {l.rx[14:0], sdi_s};
                    if (l.rd && l.bits == `RRS_READ_RELEASE)
                        ln.oe_n = 1'b1;
                    if (l.bits == `RRS_LAST_BIT)
                    begin
                        ln.serial_load_enable = 1'b1;
                        ln.edges = 2'h0;
                        ln.state = L_LOAD;
                    end
                end
            end
            L_LOAD:
            begin
                if (tick && !l.sck)
                begin
                    ln.sck = 1'b1;
                    ln.edges = l.edges + 2'h1;
                    if (l.rd && l.edges == 2'h1)
                        ln.oe_n = 1'b0;
                end
                else if (tick)
                begin
                    ln.sck = 1'b0;
                    if (l.rd && l.edges == 2'h1)
                        ln.rsp = l.rx;
                    if (l.edges == (l.rd ? 2'h2 : 2'h1))
                    begin
                        ln.serial_load_enable = 1'b0;
                        if (l.w32 && !l.second)
                        begin
                            ln.second = 1'b1;
                            ln.gap = 8'(GAP_CYC - 1);
                            ln.state = L_GAP;
                        end
                        else
                        begin
                            ln.ack_tgl = ~l.ack_tgl;
                            ln.state = L_IDLE;
                        end
                    end
                end
            end
            L_GAP:
            begin
                if (l.gap == 8'h0)
                begin
                    ln.sh = frame(KIND_WRITE, s.cmd.hdr, s.cmd.addr, s.cmd.data[`RRS_W32_LO]);
                    ln.bits = `RRS_LEN_NORMAL;
                    ln.sdo = ln.sh[24];
                    ln.state = L_SHIFT;
                end
                else
                    ln.gap = l.gap - 8'h1;
            end
            default: ln = LINK_RST;
        endcase
    end

    always_ff @(posedge i_clk_link or posedge lrst_r)
    begin
        if (lrst_r)
            l <= LINK_RST;
        else
            l <= ln;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_cmd_ready = s.ready;
    assign o_rsp_valid = s.rsp_valid;
    assign o_rsp_data = s.rsp_data;
    assign o_init_addr = s.init_addr;
    assign o_init_done = s.init_done;
    assign o_modem_data_line = s.modem;
    assign o_radio_chip_enable = s.ce;
    assign o_radio_chip_enable_oe_n = s.ce_oe_n;
    assign o_radio_sync_control = s.sync;
    assign o_radio_sync_control_oe_n = s.sync_oe_n;
    assign o_serial_shift_clock = l.sck;
    assign o_serial_load_enable = l.serial_load_enable;
    assign o_serial_data_line = l.sdo;
    assign o_serial_data_line_oe_n = l.oe_n;

    // ************************************************************
    // checks
    // ************************************************************
    logic [7:0] gap_run_r;

    always_ff @(posedge i_clk_link or posedge lrst_r)
    begin
        if (lrst_r)
            gap_run_r <= 8'h0;
        else if (l.state == L_GAP)
            gap_run_r <= gap_run_r + 8'h1;
        else
            gap_run_r <= 8'h0;
    end

    chk_header_fixed: assert property (@(posedge i_clk_link) disable iff (lrst_r)
        (l.state == L_IDLE && ln.state == L_SHIFT && !(s.cmd.kind inside {KIND_FAST16, KIND_FAST8}))
        |=> l.sh[24:22] == `RRS_HDR_NORMAL && l.sdo == l.sh[24])
        else $error("normal frame does not start with the fixed header");

    chk_idle_quiet: assert property (@(posedge i_clk_link) disable iff (lrst_r)
        l.state == L_IDLE |-> !l.serial_load_enable && !l.sck)
        else $error("load enable or shift clock active between frames");

    chk_read_release: assert property (@(posedge i_clk_link) disable iff (lrst_r)
        (l.state == L_SHIFT && tick && l.sck && l.rd && l.bits == `RRS_READ_RELEASE)
        |=> l.oe_n && l.bits == `RRS_DATA_BITS)
        else $error("data line not released after read address");

    chk_write_drive: assert property (@(posedge i_clk_link) disable iff (lrst_r)
        (l.state == L_SHIFT && !l.rd) |-> !l.oe_n)
        else $error("data line not driven during a write frame");

    chk_read_capture: assert property (@(posedge i_clk_link) disable iff (lrst_r)
        (l.state == L_LOAD && tick && l.sck && l.rd && l.edges == 2'h1) |=> l.rsp == $past(l.rx) && l.serial_load_enable)
        else $error("read word not captured at the first fall with load high");

    chk_redrive_late: assert property (@(posedge i_clk_link) disable iff (lrst_r)
        (l.state == L_LOAD && l.rd && l.edges < 2'h2) |-> l.oe_n)
        else $error("data line driven before the radio has let go");

    chk_gap_length: assert property (@(posedge i_clk_link) disable iff (lrst_r)
        $fell(l.state == L_GAP) |-> gap_run_r >= GAP_CYC)
        else $error("halves of a wide write too close together");

    chk_sck_master: assert property (@(posedge i_clk_link) disable iff (lrst_r)
        $changed(l.sck) |-> $past(l.state) inside {L_SHIFT, L_LOAD})
        else $error("shift clock moved outside a frame");

    chk_reset_pins: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
        (!i_pins_enable && !s.init_active && !$past(s.init_done)) ##1 !i_pins_enable
        |-> s.ce_oe_n && s.sync_oe_n)
        else $error("radio pins driven before they are enabled");

    cov_read_done: cover property (@(posedge i_clk_link) disable iff (lrst_r)
        l.state == L_LOAD && l.rd ##1 l.state == L_IDLE);

    cov_wide_gap: cover property (@(posedge i_clk_link) disable iff (lrst_r)
        l.state == L_GAP ##1 l.state == L_SHIFT);

    cov_init_done: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst) s.init_done);
endmodule

// *** verif/rrs_radio_model.sv ***
// Purpose: radio side of the serial register port
// Assumes: device shifts on fall, loads with sle at a rise
// Notes: an undriven line toggles so a stale value never passes
module rrs_radio_model
    import rrs_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sck,
    input wire logic i_sle,
    input wire logic i_sdo,
    input wire logic i_oe_n,
    output logic o_line
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] W32A = 5'h0a;
    logic [15:0] regs [32];
    logic [24:0] sh = '0;
    logic [24:0] last_sh;
    logic [5:0] cnt = '0;
    logic [5:0] last_cnt;
    logic [4:0] log_q [$];
    logic rd = 0;
    logic drv = 0;
    logic dq = 0;
    logic flt = 0;
    logic [15:0] word;
    logic [1:0] wc = '0;
    assign o_line = !i_oe_n ? i_sdo : (drv ? dq : ~flt);
    always @(posedge i_clk) flt <= o_line;
    always @(posedge i_sck)
    begin
        if (!i_sle)
        begin
            sh <= {sh[23:0], (rd && cnt >= 6'h09) ? word[15] : o_line};
            cnt <= cnt + 6'h01;
            if (cnt == 6'h08)
            begin
                rd <= sh[4] && sh[7:5] == 3'h5;
                word <= ({sh[3:0], o_line} == W32A) ? {15'h0, wc == 2'h2} : regs[{sh[3:0], o_line}];
            end
            if (cnt >= 6'h09 && rd)
            begin
                drv <= 1'b1;
                dq <= word[15];
                word <= word << 1;
            end
        end
        else
        begin
            drv <= 1'b0;
            // a read holds sle over two rises; keep the frame seen at the first
            if (cnt != 6'h00)
            begin
                last_sh <= sh;
                last_cnt <= cnt;
            end
            if (cnt == 6'h10) regs[5'(sh[15:13])] <= 16'(sh[12:0]);
            if (cnt == 6'h08) regs[5'(sh[7:5])] <= 16'(sh[4:0]);
            sh <= '0;
            cnt <= '0;
            rd <= 1'b0;
            if (cnt == 6'h19 && !rd)
            begin
                regs[sh[20:16]] <= sh[15:0];
                log_q.push_back(sh[20:16]);
                if (sh[20:16] == W32A) wc <= (wc == 2'h1) ? 2'h2 : 2'h1;
            end
        end
    end
endmodule

// *** verif/tb_radio_register_serial_master.sv ***
// Purpose: self-checking bench for the radio register serial master
// Assumes: baseband clock runs free at 15 ns
// Notes: frames are judged from what the radio model received
module tb_radio_register_serial_master;
    timeunit 1ns;
    timeprecision 1ps;
    import rrs_pkg::*;
    typedef struct packed {rrs_kind_e k; logic [2:0] h; logic [4:0] a; logic [31:0] d;
        logic [5:0] n; logic [24:0] b; logic [15:0] r;} rrs_row_s;
    localparam logic [4:0] ORD [14] = '{5'h11, 5'h0f, 5'h0e, 5'h0c, 5'h0b, 5'h0a, 5'h09,
        5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h02, 5'h01};
    logic clk = 0, lclk = 0, rst = 1, valid = 0, start = 0, pen = 0, ce = 0, sy = 0;
    rrs_cmd_s cmd = '0;
    logic ready, rv, done, modem, ceo, ce_oe_n, syo, sy_oe_n, sck, serial_load_enable, sdo, sd_oe_n, line;
    logic [15:0] rdata;
    logic [4:0] iaddr;
    int miscompares = 0, n_tests = 0, cyc = 0;
    rrs_row_s rows [6];
    always #10 clk = ~clk;
    // offset so that no link edge meets a system edge
    initial
    begin
        #3.3;
        forever #7.5 lclk = ~lclk;
    end
    rrs_serial_master dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_link(lclk), .i_cmd_valid(valid),
        .i_cmd(cmd), .o_cmd_ready(ready), .o_rsp_valid(rv), .o_rsp_data(rdata), .i_init_start(start),
        .o_init_addr(iaddr), .i_init_entry({1'b0, 27'h0, iaddr}), .o_init_done(done),
        .i_pins_enable(pen), .i_radio_chip_enable(ce), .i_radio_sync_control(sy),
        .o_modem_data_line(modem), .o_radio_chip_enable(ceo), .o_radio_chip_enable_oe_n(ce_oe_n),
        .o_radio_sync_control(syo), .o_radio_sync_control_oe_n(sy_oe_n), .o_serial_shift_clock(sck),
        .o_serial_load_enable(serial_load_enable), .o_serial_data_line(sdo), .o_serial_data_line_oe_n(sd_oe_n),
        .i_serial_data_line(line));
    rrs_radio_model radio (.i_clk(lclk), .i_sck(sck), .i_sle(serial_load_enable), .i_sdo(sdo), .i_oe_n(sd_oe_n),
        .o_line(line));
    function automatic logic [24:0] fr(input logic w, input logic [4:0] a, input logic [15:0] d);
        return {3'h5, w, a, d};
    endfunction
    task automatic chk(input logic [24:0] got, input logic [24:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic run(input rrs_row_s r);
        @(negedge clk);
        cmd = '{r.k, r.h, r.a, r.d};
        valid = 1;
        @(negedge clk);
        valid = 0;
        while (rv !== 1'b1) @(negedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            miscompares++;
            complete_run();
        end
    end
    initial
    begin
        rows[0] = '{KIND_WRITE, 3'h0, 5'h03, 32'ha5c3, 6'h19, fr(1'b0, 5'h03, 16'ha5c3), 16'h0};
        rows[1] = '{KIND_READ, 3'h0, 5'h03, 32'h0, 6'h19, fr(1'b1, 5'h03, 16'ha5c3), 16'ha5c3};
        rows[2] = '{KIND_WRITE32, 3'h0, 5'h0a, 32'hffffdc04, 6'h19, fr(1'b0, 5'h0a, 16'hdc04), 16'h0};
        rows[3] = '{KIND_READ, 3'h0, 5'h0a, 32'h0, 6'h19, fr(1'b1, 5'h0a, 16'h0001), 16'h0001};
        rows[4] = '{KIND_FAST16, 3'h3, 5'h0, 32'h1abc, 6'h10, {9'h0, 3'h3, 13'h1abc}, 16'h0};
        rows[5] = '{KIND_FAST8, 3'h6, 5'h0, 32'h15, 6'h08, {17'h0, 3'h6, 5'h15}, 16'h0};
        repeat (16) @(posedge clk);
        chk({modem, ce_oe_n, sy_oe_n, sd_oe_n}, 25'hf);
        chk({serial_load_enable, sck}, 25'h0);
        @(negedge clk);
        rst = 0;
        repeat (10) @(negedge clk);
        foreach (rows[i])
        begin
            run(rows[i]);
            chk(25'(radio.last_cnt), 25'(rows[i].n));
            chk(radio.last_sh, rows[i].b);
            if (rows[i].k == KIND_READ) chk(25'(rdata), 25'(rows[i].r));
        end
        chk({serial_load_enable, sck}, 25'h0);
        pen = 1;
        ce = 1;
        sy = 1;
        repeat (2) @(negedge clk);
        chk({ceo, syo, ce_oe_n, sy_oe_n}, 25'hc);
        radio.log_q.delete();
        start = 1;
        @(negedge clk);
        start = 0;
        while (done !== 1'b1) @(negedge clk);
        @(negedge clk);
        chk(25'({modem, ready}), 25'h1);
        chk(25'(radio.log_q.size()), 25'h0e);
        foreach (ORD[i]) chk(25'(radio.log_q[i]), 25'(ORD[i]));
        complete_run();
    end
endmodule
